// *** shared/dfl_defs.svh ***
// Purpose: Constants for the drive fault detect and latch block.
// Assumes: Included by its bare name.
// Notes: Codes are the reported main and sub fault codes.
`ifndef DFL_DEFS_SVH
`define DFL_DEFS_SVH
`define DFL_MAIN_ASSIGN 8'h21
`define DFL_SUB_CNT_RST 4'h6
`define DFL_SUB_PULSE_GATE 4'h7
`define DFL_MAIN_TRAVEL 8'h22
`define DFL_MAIN_PARAM 8'h24
`define DFL_MAIN_CHECK 8'h25
`define DFL_MAIN_OVERTRAVEL 8'h26
`define DFL_MAIN_ANALOG 8'h27
`define DFL_SUB_ZERO 4'h0
`define DFL_SUB_ONE 4'h1
`define DFL_SUB_TWO 4'h2
`define DFL_MAIN_NONE 8'h00
`define DFL_INPUT_SEVENTH 4'h6
`define DFL_INPUT_TENTH 4'h9
`define DFL_OT_MODE_BOTH 2'h0
`define DFL_OT_MODE_EITHER 2'h2
`define DFL_NUM_INPUTS 10
`endif

// *** shared/dfl_pkg.sv ***
// Purpose: Types for the drive fault detect and latch block.
// Assumes: Nothing beyond the defs header.
// Notes: Fault sources are ranked in enum order, first is highest.
package dfl_pkg;
	typedef logic [7:0] dfl_main_t;
	typedef logic [3:0] dfl_sub_t;
	typedef enum logic [3:0] {
		DFL_F_NONE,
		DFL_F_CNT_RST,
		DFL_F_PULSE_GATE,
		DFL_F_PARAM,
		DFL_F_CHECK,
		DFL_F_OVERTRAVEL,
		DFL_F_TRAVEL,
		DFL_F_AN1,
		DFL_F_AN2,
		DFL_F_AN3
	} dfl_src_e;
endpackage : dfl_pkg

// *** logic/dfl_sync.sv ***
// Purpose: Two-stage synchroniser for a vector of pin levels.
// Assumes: Inputs are static levels from outside the clock domain.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/1ps
module dfl_sync #(
	parameter int WIDTH = 2
) (
	input wire logic clock_i, // System clock
	input wire logic rst_n_i, // Async reset, active low
	input wire logic [WIDTH-1:0] async_i, // Raw levels
	output logic [WIDTH-1:0] sync_o // Synchronised levels
);
	logic [WIDTH-1:0] meta_q;
	if (WIDTH < 1) begin : g_bad_width
		$error("dfl_sync: WIDTH must be positive");
	end
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= '0;
			sync_o <= '0;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule : dfl_sync

// *** logic/dfl_fault_latch.sv ***
// What this block does
// RL1 - Counter reset not on seventh input: 33/6
// RL2 - Pulse gate not on tenth input: 33/7
// RL3 - Motion beyond travel range: fault 34/0
// RL4 - Travel range limit zero disables check
// RL5 - Corrupted stored parameters at power-on: 36/x
// RL6 - Corrupted write-check data at power-on: 37/x
// RL7 - Mode 0: both travel blocks faults
// RL8 - Mode 2: either travel block faults
// RL9 - First analog over threshold: 39/0
// RL10 - Second analog over threshold: 39/1
// RL11 - Third analog over threshold: 39/2
// RL12 - Zero threshold disables that analog check
// RL13 - Mapping, storage, over-travel survive fault reset
// RL14 - Codes latch; reset clears travel, analog
// Purpose: Detect drive faults, report and latch main and sub codes.
// Assumes: Settings and analog samples are on clock_i; limit switches are pins.
// Notes: The first fault latched holds the code until it is cleared.
`timescale 1ns/1ps
`include "dfl_defs.svh"
module dfl_fault_latch
	import dfl_pkg::*;
#(
	parameter int POS_W = 32,
	parameter int AN_W = 12,
	parameter int NUM_INPUTS = `DFL_NUM_INPUTS
) (
	input wire logic clock_i, // System clock, 100 MHz
	input wire logic rst_n_i, // Power-on reset, active low
	input wire logic [3:0] count_reset_select_i, // Input index carrying counter reset
	input wire logic count_reset_select_en_i, // Counter reset function is mapped
	input wire logic [3:0] pulse_gate_input_i, // Input index carrying pulse gate
	input wire logic pulse_gate_input_en_i, // Pulse gate function is mapped
	input wire logic [POS_W-1:0] position_dev_i, // Motor travel beyond command, magnitude
	input wire logic command_in_range_i, // Position command within input range
	input wire logic [POS_W-1:0] travel_range_limit_i, // Working range, zero disables
	input wire logic param_check_done_i, // Storage readback finished, pulse
	input wire logic param_corrupt_i, // Parameter area corrupted
	input wire logic [1:0] param_sub_i, // Sub code for parameter fault
	input wire logic check_corrupt_i, // Write-check data corrupted
	input wire logic [1:0] check_sub_i, // Sub code for write-check fault
	input wire logic [1:0] overtravel_mode_setting_i, // Over-travel mode
	input wire logic positive_travel_block_i, // Positive block pin, active high
	input wire logic negative_travel_block_i, // Negative block pin, active high
	input wire logic [AN_W-1:0] analog_in_first_i, // First analog sample
	input wire logic [AN_W-1:0] analog_in_second_i, // Second analog sample
	input wire logic [AN_W-1:0] analog_in_third_i, // Third analog sample
	input wire logic [AN_W-1:0] analog_first_threshold_i, // First limit, zero disables
	input wire logic [AN_W-1:0] analog_second_threshold_i, // Second limit, zero disables
	input wire logic [AN_W-1:0] analog_third_threshold_i, // Third limit, zero disables
	input wire logic fault_reset_input_i, // Fault reset pin, active high
	output dfl_pkg::dfl_main_t fault_main_o, // Latched main code, zero when clear
	output dfl_pkg::dfl_sub_t fault_sub_o, // Latched sub code
	output logic fault_active_o, // A fault is latched
	output logic fault_sticky_o // Latched fault needs power cycle
);
	import dfl_pkg::*;

	logic [2:0] pins_sync;
	logic pos_blk, neg_blk, rst_req;
	logic [2:0] an_over;
	logic [AN_W-1:0] an_val [3];
	logic [AN_W-1:0] an_thr [3];
	dfl_src_e src_d;
	dfl_main_t main_d;
	dfl_sub_t sub_d;
	logic sticky_d;
	logic param_q, check_q;
	logic [1:0] param_sub_q, check_sub_q;

	// Index ports are four bits wide and must reach the tenth input
	if (NUM_INPUTS < 10 || NUM_INPUTS > 16 || AN_W < 1 || POS_W < 1) begin : g_bad_param
		$error("dfl_fault_latch: unsupported parameter value");
	end

	dfl_sync #(.WIDTH(3)) u_sync (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.async_i({fault_reset_input_i, negative_travel_block_i, positive_travel_block_i}),
		.sync_o(pins_sync)
	);
	assign pos_blk = pins_sync[0];
	assign neg_blk = pins_sync[1];
	assign rst_req = pins_sync[2];

	assign an_val[0] = analog_in_first_i;
	assign an_val[1] = analog_in_second_i;
	assign an_val[2] = analog_in_third_i;
	assign an_thr[0] = analog_first_threshold_i;
	assign an_thr[1] = analog_second_threshold_i;
	assign an_thr[2] = analog_third_threshold_i;

	// RL12 zero threshold disable
	for (genvar g = 0; g < 3; g++) begin : g_an
		// RL9 RL10 RL11 per-channel compare
		assign an_over[g] = (an_thr[g] != '0) && (an_val[g] > an_thr[g]);
	end

	// Storage results only count on the power-on readback strobe
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			param_q <= 1'b0;
			check_q <= 1'b0;
			param_sub_q <= 2'h0;
			check_sub_q <= 2'h0;
		end else if (param_check_done_i) begin
			param_q <= param_corrupt_i;
			check_q <= check_corrupt_i;
			param_sub_q <= param_sub_i;
			check_sub_q <= check_sub_i;
		end
	end

	// Highest ranked new fault this cycle
	always_comb begin
		src_d = DFL_F_NONE;
		main_d = `DFL_MAIN_NONE;
		sub_d = `DFL_SUB_ZERO;
		sticky_d = 1'b0;
		if (an_over[2]) begin
			src_d = DFL_F_AN3;
			main_d = `DFL_MAIN_ANALOG;
			sub_d = `DFL_SUB_TWO;
		end
		if (an_over[1]) begin
			src_d = DFL_F_AN2;
			main_d = `DFL_MAIN_ANALOG;
			sub_d = `DFL_SUB_ONE;
		end
		if (an_over[0]) begin
			src_d = DFL_F_AN1;
			main_d = `DFL_MAIN_ANALOG;
			sub_d = `DFL_SUB_ZERO;
		end
		// RL3 RL4 travel range check
		if (travel_range_limit_i != '0 && command_in_range_i && position_dev_i > travel_range_limit_i) begin
			src_d = DFL_F_TRAVEL;
			main_d = `DFL_MAIN_TRAVEL;
			sub_d = `DFL_SUB_ZERO;
		end
		// RL7 RL8 over-travel combinations
		if ((overtravel_mode_setting_i == `DFL_OT_MODE_BOTH && pos_blk && neg_blk) ||
				(overtravel_mode_setting_i == `DFL_OT_MODE_EITHER && (pos_blk || neg_blk))) begin
			src_d = DFL_F_OVERTRAVEL;
			main_d = `DFL_MAIN_OVERTRAVEL;
			sub_d = `DFL_SUB_ZERO;
			sticky_d = 1'b1;
		end
		// RL6 write-check corruption
		if (check_q) begin
			src_d = DFL_F_CHECK;
			main_d = `DFL_MAIN_CHECK;
			sub_d = {2'h0, check_sub_q};
			sticky_d = 1'b1;
		end
		// RL5 parameter corruption
		if (param_q) begin
			src_d = DFL_F_PARAM;
			main_d = `DFL_MAIN_PARAM;
			sub_d = {2'h0, param_sub_q};
			sticky_d = 1'b1;
		end
		// RL2 pulse gate mapping
		if (pulse_gate_input_en_i && pulse_gate_input_i != `DFL_INPUT_TENTH) begin
			src_d = DFL_F_PULSE_GATE;
			main_d = `DFL_MAIN_ASSIGN;
			sub_d = `DFL_SUB_PULSE_GATE;
			sticky_d = 1'b1;
		end
		// RL1 counter reset mapping
		if (count_reset_select_en_i && count_reset_select_i != `DFL_INPUT_SEVENTH) begin
			src_d = DFL_F_CNT_RST;
			main_d = `DFL_MAIN_ASSIGN;
			sub_d = `DFL_SUB_CNT_RST;
			sticky_d = 1'b1;
		end
	end

	// RL14 latch first fault, RL13 sticky survives reset
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fault_main_o <= `DFL_MAIN_NONE;
			fault_sub_o <= `DFL_SUB_ZERO;
			fault_active_o <= 1'b0;
			fault_sticky_o <= 1'b0;
		end else if (!fault_active_o || (rst_req && !fault_sticky_o)) begin
			// A new fault in the reset cycle wins over the clear
			fault_main_o <= main_d;
			fault_sub_o <= sub_d;
			fault_active_o <= (src_d != DFL_F_NONE);
			fault_sticky_o <= sticky_d;
		end
	end

	sticky_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL13
		fault_sticky_o |=> fault_sticky_o && $stable(fault_main_o))
		else $error("sticky fault changed");
	clear_works_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL14
		fault_active_o && !fault_sticky_o && rst_req && src_d == DFL_F_NONE |=> !fault_active_o)
		else $error("resettable fault not cleared");
	cnt_map_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL1
		!fault_active_o && count_reset_select_en_i && count_reset_select_i != `DFL_INPUT_SEVENTH
		|=> fault_main_o == `DFL_MAIN_ASSIGN && fault_sub_o == `DFL_SUB_CNT_RST)
		else $error("counter reset mapping fault missing");
	gate_map_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL2
		!fault_active_o && pulse_gate_input_en_i && pulse_gate_input_i != `DFL_INPUT_TENTH
		|=> fault_main_o == `DFL_MAIN_ASSIGN && fault_sticky_o)
		else $error("pulse gate mapping fault missing");
	travel_off_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL4
		travel_range_limit_i == '0 |-> src_d != DFL_F_TRAVEL)
		else $error("travel check not disabled");
	travel_hit_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL3
		src_d == DFL_F_TRAVEL && !fault_active_o |=> fault_main_o == `DFL_MAIN_TRAVEL && !fault_sticky_o)
		else $error("travel fault code wrong");
	param_hit_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL5
		param_check_done_i && param_corrupt_i ##1 !fault_active_o && src_d == DFL_F_PARAM
		|=> fault_main_o == `DFL_MAIN_PARAM)
		else $error("parameter fault code wrong");
	check_hit_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL6
		!fault_active_o && src_d == DFL_F_CHECK |=> fault_main_o == `DFL_MAIN_CHECK && fault_sticky_o)
		else $error("write-check fault code wrong");
	ot_both_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL7
		overtravel_mode_setting_i == `DFL_OT_MODE_BOTH && pos_blk && !neg_blk |-> src_d != DFL_F_OVERTRAVEL)
		else $error("mode 0 single block faulted");
	// Every fault ranked at or above over-travel is sticky
	ot_either_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL8
		overtravel_mode_setting_i == `DFL_OT_MODE_EITHER && (pos_blk || neg_blk) && !fault_active_o
		|=> fault_active_o && fault_sticky_o)
		else $error("mode 2 block not latched");
	an_first_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL9
		!fault_active_o && src_d == DFL_F_AN1 |=> fault_main_o == `DFL_MAIN_ANALOG && fault_sub_o == `DFL_SUB_ZERO)
		else $error("first analog fault code wrong");
	an_zero_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL12
		analog_second_threshold_i == '0 |-> !an_over[1])
		else $error("analog check not disabled");
	an_third_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL11
		!fault_active_o && analog_third_threshold_i != '0 && analog_in_third_i > analog_third_threshold_i
		|=> fault_active_o)
		else $error("third analog over missed");
	an_second_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RL10
		!fault_active_o && src_d == DFL_F_AN2 |=> fault_sub_o == `DFL_SUB_ONE)
		else $error("second analog sub code wrong");

	sticky_cov: cover property (@(posedge clock_i) disable iff (!rst_n_i) $rose(fault_sticky_o));
	clear_cov: cover property (@(posedge clock_i) disable iff (!rst_n_i) $fell(fault_active_o));
	analog_cov: cover property (@(posedge clock_i) disable iff (!rst_n_i) src_d == DFL_F_AN3 && !fault_active_o);
endmodule : dfl_fault_latch

// *** test/dfl_far_side.sv ***
// Purpose: Far-side model of the limit switches and the fault reset button.
// Assumes: Requests come from the bench; the pins are asynchronous to the drive clock.
// Notes: Pins lag requests by 3 ns, so a pin edge never lands on a clock edge.
`timescale 1ns/1ps
module dfl_far_side (
	input wire logic pos_req_i, // Close positive limit switch
	input wire logic neg_req_i, // Close negative limit switch
	input wire logic clr_req_i, // Press fault reset button
	output logic positive_travel_block_o, // Positive block pin
	output logic negative_travel_block_o, // Negative block pin
	output logic fault_reset_input_o // Fault reset pin
);
	// Wiring delay, also models contact lag of real switches
	// Continuous drive so the pins show the released level from 3 ns on
	assign #3 positive_travel_block_o = pos_req_i;
	assign #3 negative_travel_block_o = neg_req_i;
	assign #3 fault_reset_input_o = clr_req_i;
endmodule : dfl_far_side

// *** test/dfl_tb.sv ***
// Purpose: Self-checking bench for the fault detect and latch block.
// Assumes: Fixed waits cover the 1, 2 and 3 cycle answer times of the block.
// Notes: Sticky faults are only left by a power reset.
`timescale 1ns/1ps
`include "dfl_defs.svh"
module tb;
	import dfl_pkg::*;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [3:0] crs = 4'h6, pgi = 4'h9;
	logic crs_en = 1'b0, pg_en = 1'b0, in_rng = 1'b0, done = 1'b0, pc = 1'b0, cc = 1'b0;
	logic pos = 1'b0, neg = 1'b0, clr = 1'b0, pos_pin, neg_pin, clr_pin;
	logic [1:0] ps = 2'h0, cs = 2'h0, mode = 2'h1;
	logic [31:0] dev = 32'h0, lim = 32'h0;
	logic [11:0] an [3] = '{12'h0, 12'h0, 12'h0};
	logic [11:0] th [3] = '{12'h0, 12'h0, 12'h0};
	dfl_main_t fault_main_o;
	dfl_sub_t fault_sub_o;
	logic fault_active_o, fault_sticky_o;
	int mismatches = 0;
	int checked = 0;
	always #5 clock_i = ~clock_i;
	dfl_far_side far (.pos_req_i(pos), .neg_req_i(neg), .clr_req_i(clr), .positive_travel_block_o(pos_pin),
		.negative_travel_block_o(neg_pin), .fault_reset_input_o(clr_pin));
	dfl_fault_latch dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .count_reset_select_i(crs),
		.count_reset_select_en_i(crs_en), .pulse_gate_input_i(pgi), .pulse_gate_input_en_i(pg_en),
		.position_dev_i(dev), .command_in_range_i(in_rng), .travel_range_limit_i(lim),
		.param_check_done_i(done), .param_corrupt_i(pc), .param_sub_i(ps), .check_corrupt_i(cc),
		.check_sub_i(cs), .overtravel_mode_setting_i(mode), .positive_travel_block_i(pos_pin),
		.negative_travel_block_i(neg_pin), .analog_in_first_i(an[0]), .analog_in_second_i(an[1]),
		.analog_in_third_i(an[2]), .analog_first_threshold_i(th[0]), .analog_second_threshold_i(th[1]),
		.analog_third_threshold_i(th[2]), .fault_reset_input_i(clr_pin), .fault_main_o(fault_main_o),
		.fault_sub_o(fault_sub_o), .fault_active_o(fault_active_o), .fault_sticky_o(fault_sticky_o));
	task automatic stop_test;
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : stop_test
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : cyc
	task automatic expect_fault(input dfl_main_t m, input dfl_sub_t s, input logic st);
		checked++;
		if ({fault_main_o, fault_sub_o, fault_sticky_o, fault_active_o} !== {m, s, st, m != 8'h00}) begin
			mismatches++;
			$display("BAD t=%0t got %h exp %h", $time, {fault_main_o, fault_sub_o, fault_sticky_o,
				fault_active_o}, {m, s, st, m != 8'h00});
		end
	endtask : expect_fault
	task automatic power_reset;
		rst_n_i = 1'b0;
		cyc(2);
		rst_n_i = 1'b1;
		cyc(1);
	endtask : power_reset
	// Button pressed long enough to pass the pin synchroniser
	task automatic clear_pin;
		clr = 1'b1;
		cyc(5);
		clr = 1'b0;
		cyc(5);
	endtask : clear_pin
	task automatic analog_test;
		for (int i = 0; i < 3; i++) begin
			th[i] = 12'h800;
			an[i] = 12'h800;
			cyc(3);
			expect_fault(`DFL_MAIN_NONE, 4'h0, 1'b0); // equal is not over
			an[i] = 12'h801;
			cyc(3);
			expect_fault(`DFL_MAIN_ANALOG, 4'(i), 1'b0); // over by one
			an[i] = 12'h000;
			clear_pin();
			expect_fault(`DFL_MAIN_NONE, 4'h0, 1'b0); // reset clears it
			th[i] = 12'h000;
			an[i] = 12'hFFF;
			cyc(3);
			expect_fault(`DFL_MAIN_NONE, 4'h0, 1'b0); // zero limit disables
			an[i] = 12'h000;
		end
	endtask : analog_test
	task automatic travel_test;
		dev = 32'h0000_1000;
		in_rng = 1'b1;
		cyc(3);
		expect_fault(`DFL_MAIN_NONE, 4'h0, 1'b0); // zero limit disables
		lim = 32'h0000_0FFF;
		cyc(3);
		expect_fault(`DFL_MAIN_TRAVEL, 4'h0, 1'b0); // beyond range
		dev = 32'h0;
		clear_pin();
		expect_fault(`DFL_MAIN_NONE, 4'h0, 1'b0); // reset clears it
	endtask : travel_test
	task automatic map_test;
		crs_en = 1'b1;
		pg_en = 1'b1;
		cyc(3);
		expect_fault(`DFL_MAIN_NONE, 4'h0, 1'b0); // correct inputs
		crs = 4'h5;
		cyc(3);
		expect_fault(`DFL_MAIN_ASSIGN, `DFL_SUB_CNT_RST, 1'b1); // wrong input
		crs = 4'h6;
		clear_pin();
		expect_fault(`DFL_MAIN_ASSIGN, `DFL_SUB_CNT_RST, 1'b1); // survives reset pin
		power_reset();
		pgi = 4'h8;
		cyc(3);
		expect_fault(`DFL_MAIN_ASSIGN, `DFL_SUB_PULSE_GATE, 1'b1); // wrong input
		pgi = 4'h9;
		power_reset();
		expect_fault(`DFL_MAIN_NONE, 4'h0, 1'b0); // power cycle clears
	endtask : map_test
	task automatic store_test;
		for (int k = 0; k < 2; k++) begin
			pc = (k == 0);
			cc = (k == 1);
			ps = 2'h1;
			cs = 2'h2;
			done = 1'b1;
			cyc(1);
			done = 1'b0;
			cyc(3);
			expect_fault(k ? `DFL_MAIN_CHECK : `DFL_MAIN_PARAM, 4'(k + 1), 1'b1); // corrupt
			clear_pin();
			expect_fault(k ? `DFL_MAIN_CHECK : `DFL_MAIN_PARAM, 4'(k + 1), 1'b1); // still held
			pc = 1'b0;
			cc = 1'b0;
			power_reset();
		end
	endtask : store_test
	task automatic ot_test;
		mode = `DFL_OT_MODE_BOTH;
		pos = 1'b1;
		cyc(5);
		expect_fault(`DFL_MAIN_NONE, 4'h0, 1'b0); // one block is not enough
		neg = 1'b1;
		cyc(5);
		expect_fault(`DFL_MAIN_OVERTRAVEL, 4'h0, 1'b1); // both blocks
		pos = 1'b0;
		neg = 1'b0;
		clear_pin();
		expect_fault(`DFL_MAIN_OVERTRAVEL, 4'h0, 1'b1); // still held
		power_reset();
		mode = `DFL_OT_MODE_EITHER;
		neg = 1'b1;
		cyc(5);
		expect_fault(`DFL_MAIN_OVERTRAVEL, 4'h0, 1'b1); // either block
		neg = 1'b0;
		mode = 2'h1;
		power_reset();
	endtask : ot_test
	initial begin
		cyc(2);
		rst_n_i = 1'b1;
		cyc(1);
		analog_test();
		travel_test();
		map_test();
		store_test();
		ot_test();
		stop_test();
	end
	// Whole run needs well under 2000 cycles
	initial begin
		#200000;
		mismatches++;
		stop_test();
	end
endmodule : tb
